// [ext_mem_read_consts.vh]
`ifndef EXT_MEM_READ_CONSTS_VH
`define EXT_MEM_READ_CONSTS_VH
// Register byte offsets (APB, one aligned word each)
`define OFF_BUS_CONTROL 12'h000
`define OFF_PORTF_FUNC 12'h004
`define OFF_PORTF_PULLUP 12'h008
`define OFF_SYS_PULLUP_DIS 12'h00C
`define OFF_READ_ADDR 12'h010
`define OFF_READ_CMD 12'h014
`define OFF_READ_DATA 12'h018
`define OFF_STATUS 12'h01C
// Field positions
`define BCR_DRV_BIT 0
`define BCR_WAIT_LSB 4
`define BCR_WAIT_MSB 7
`define PUDR_CTRL_BIT 0
`define CMD_SPACE_BIT 0
`define CMD_CS_LSB 4
`define CMD_CS_MSB 7
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
// Reset values
`define RST_BUS_CONTROL 32'h00000000
`define RST_PORTF_FUNC 16'h0000
`define RST_PORTF_PULLUP 16'hFFFF
`define RST_WAIT 4'h2
`endif

// [ext_mem_read.v]
// The APB slave port and the placing of the registers were decided locally.
`include "ext_mem_read_consts.vh"

module ext_mem_read #(
   parameter ADDR_WIDTH = 24,         // External address width
   parameter DATA_WIDTH = 16,         // External data width
   parameter GPIO_WIDTH = 9,          // Upper data pins shared with port F
   parameter CS_WIDTH = 4             // Chip-select lines
) (
   input wire clock,                  // 100 MHz system clock
   input wire nrst,                   // Synchronous reset, active low
   input wire psel,                   // APB select
   input wire penable,                // APB access phase
   input wire pwrite,                 // APB direction
   input wire [11:0] paddr,           // APB byte address
   input wire [31:0] pwdata,          // APB write data
   output reg [31:0] prdata,          // APB read data
   output wire pready,                // APB ready, always one
   output wire pslverr,               // APB error on unmapped address
   output reg readStrobeN,            // Read strobe level when driven
   output reg readStrobeOe,           // Read strobe output enable
   output wire readStrobePullup,      // Read strobe pull-up enable
   output reg [ADDR_WIDTH-1:0] extAddrPins,   // Address outputs
   output reg programSpaceSelectN,    // Program space select
   output reg dataSpaceSelectN,       // Data space select
   output reg [CS_WIDTH-1:0] chipSelectN,     // Chip selects
   input wire [DATA_WIDTH-1:0] extDataIn,     // Data pin levels
   output wire [DATA_WIDTH-1:0] extDataOut,   // Data pin drive values
   output wire [DATA_WIDTH-1:0] extDataOe,    // Data pin output enables
   output wire [DATA_WIDTH-1:0] extDataPullup,// Data pin pull-up enables
   input wire [GPIO_WIDTH-1:0] gpioOut,       // Port F drive values
   input wire [GPIO_WIDTH-1:0] gpioDir,       // Port F direction, 1 = out
   output wire [GPIO_WIDTH-1:0] gpioIn        // Port F pin levels
);

   localparam LOW_BITS = DATA_WIDTH - GPIO_WIDTH;
   localparam ST_IDLE = 2'h0;
   localparam ST_STROBE = 2'h1;
   localparam ST_DONE = 2'h2;

   reg [31:0] busCtl_reg;
   reg [GPIO_WIDTH-1:0] gpioFunc_reg;
   reg [DATA_WIDTH-1:0] pullupEn_reg;
   reg ctrlPullupDis_reg;
   reg [ADDR_WIDTH-1:0] readAddr_reg;
   reg [DATA_WIDTH-1:0] readData_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   // One bit wider than the wait field, so the longest wait plus the fixed part cannot wrap
   reg [4:0] waitCnt_reg;
   reg done_reg;
   reg cmdSpace_reg;
   reg [CS_WIDTH-1:0] cmdCs_reg;
   reg [DATA_WIDTH-1:0] dataSync1_reg;
   reg [DATA_WIDTH-1:0] dataSync2_reg;

   wire wrAccess;
   wire rdAccess;
   wire cmdWrite;
   wire idleDrive;
   wire strobeLow;
   wire [DATA_WIDTH-1:0] gpioDirFull;
   wire [DATA_WIDTH-1:0] gpioOutFull;
   wire [DATA_WIDTH-1:0] gpioRoleFull;

   // Decode shared by read and write paths
   function mapped;
      input [11:0] a;
      begin
         case (a)
            `OFF_BUS_CONTROL,
            `OFF_PORTF_FUNC,
            `OFF_PORTF_PULLUP,
            `OFF_SYS_PULLUP_DIS,
            `OFF_READ_ADDR,
            `OFF_READ_CMD,
            `OFF_READ_DATA,
            `OFF_STATUS:
               mapped = 1'b1;
            default:
               mapped = 1'b0;
         endcase
      end
   endfunction

   // Zero-wait APB slave; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);
   assign wrAccess = psel && penable && pwrite && mapped(paddr);
   assign rdAccess = psel && penable && !pwrite;
   assign cmdWrite = wrAccess && (paddr == `OFF_READ_CMD) && (state_reg == ST_IDLE);
   assign idleDrive = busCtl_reg[`BCR_DRV_BIT];

   // Register writes; a command during a cycle is ignored
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         busCtl_reg <= `RST_BUS_CONTROL;
         gpioFunc_reg <= {GPIO_WIDTH{1'b0}};
         pullupEn_reg <= `RST_PORTF_PULLUP;
         ctrlPullupDis_reg <= 1'b0;
         readAddr_reg <= {ADDR_WIDTH{1'b0}};
         cmdSpace_reg <= 1'b0;
         cmdCs_reg <= {CS_WIDTH{1'b0}};
      end
      else if (wrAccess)
      begin
         case (paddr)
            `OFF_BUS_CONTROL:
            begin
               busCtl_reg <= pwdata;
            end
            `OFF_PORTF_FUNC:
            begin
               gpioFunc_reg <= pwdata[GPIO_WIDTH-1:0];
            end
            `OFF_PORTF_PULLUP:
            begin
               pullupEn_reg <= pwdata[DATA_WIDTH-1:0];
            end
            `OFF_SYS_PULLUP_DIS:
            begin
               ctrlPullupDis_reg <= pwdata[`PUDR_CTRL_BIT];
            end
            `OFF_READ_ADDR:
            begin
               readAddr_reg <= pwdata[ADDR_WIDTH-1:0];
            end
            `OFF_READ_CMD:
            begin
               if (state_reg == ST_IDLE)
               begin
                  cmdSpace_reg <= pwdata[`CMD_SPACE_BIT];
                  cmdCs_reg <= pwdata[`CMD_CS_MSB:`CMD_CS_LSB];
               end
            end
            default: ;
         endcase
      end
   end

   // Read mux
   always @*
   begin
      prdata = 32'h00000000;
      if (rdAccess)
      begin
         case (paddr)
            `OFF_BUS_CONTROL:
            begin
               prdata = busCtl_reg;
            end
            `OFF_PORTF_FUNC:
            begin
               prdata[GPIO_WIDTH-1:0] = gpioFunc_reg;
            end
            `OFF_PORTF_PULLUP:
            begin
               prdata[DATA_WIDTH-1:0] = pullupEn_reg;
            end
            `OFF_SYS_PULLUP_DIS:
            begin
               prdata[`PUDR_CTRL_BIT] = ctrlPullupDis_reg;
            end
            `OFF_READ_ADDR:
            begin
               prdata[ADDR_WIDTH-1:0] = readAddr_reg;
            end
            `OFF_READ_CMD:
            begin
               prdata[`CMD_CS_MSB:`CMD_CS_LSB] = cmdCs_reg;
            end
            `OFF_READ_DATA:
            begin
               prdata[DATA_WIDTH-1:0] = readData_reg;
            end
            `OFF_STATUS:
            begin
               prdata[`STAT_BUSY_BIT] = (state_reg != ST_IDLE);
               prdata[`STAT_DONE_BIT] = done_reg;
            end
            default:
            begin
               prdata = 32'h00000000;
            end
         endcase
      end
   end

   // Read cycle sequencer: strobe held low for the programmed wait count plus three cycles
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (cmdWrite)
               state_next = ST_STROBE;
         end
         ST_STROBE:
         begin
            if (waitCnt_reg == 5'h00)
               state_next = ST_DONE;
         end
         ST_DONE:
         begin
            state_next = ST_IDLE;
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   assign strobeLow = (state_reg == ST_STROBE);

   // Data pins pass two flops; the capture uses the settled copy
   always @(posedge clock)
   begin
      dataSync1_reg <= extDataIn;
      dataSync2_reg <= dataSync1_reg;
   end

   // Sequencer state, wait count, capture and done flag
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         state_reg <= ST_IDLE;
         waitCnt_reg <= {1'b0, `RST_WAIT};
         readData_reg <= {DATA_WIDTH{1'b0}};
         done_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (cmdWrite)
            waitCnt_reg <= {1'b0, busCtl_reg[`BCR_WAIT_MSB:`BCR_WAIT_LSB]} + {1'b0, `RST_WAIT};
         else if (strobeLow && waitCnt_reg != 5'h00)
            waitCnt_reg <= waitCnt_reg - 5'h01;
         // Latched as the strobe rises, so the sample is the value held under it
         if (state_reg == ST_STROBE && state_next == ST_DONE)
            readData_reg <= dataSync2_reg;
         // New completion wins over a clear by the status read
         if (state_reg == ST_STROBE && state_next == ST_DONE)
            done_reg <= 1'b1;
         else if (rdAccess && paddr == `OFF_STATUS)
            done_reg <= 1'b0;
      end
   end

   // Strobe and qualifiers come from flops so they switch together
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         readStrobeN <= 1'b1;
         readStrobeOe <= 1'b0;
         extAddrPins <= {ADDR_WIDTH{1'b0}};
         programSpaceSelectN <= 1'b1;
         dataSpaceSelectN <= 1'b1;
         chipSelectN <= {CS_WIDTH{1'b1}};
      end
      else
      begin
         readStrobeN <= !(state_next == ST_STROBE);
         // Idle tri-state unless the drive-control bit keeps it driven
         readStrobeOe <= (state_next == ST_STROBE) || idleDrive;
         if (cmdWrite)
            extAddrPins <= readAddr_reg;
         programSpaceSelectN <= !(state_next == ST_STROBE && !cmdSpace_reg && !cmdWrite)
                                && !(cmdWrite && !pwdata[`CMD_SPACE_BIT]);
         dataSpaceSelectN <= !(state_next == ST_STROBE && cmdSpace_reg && !cmdWrite)
                             && !(cmdWrite && pwdata[`CMD_SPACE_BIT]);
         chipSelectN <= (state_next == ST_STROBE) ?
                        ~(cmdWrite ? pwdata[`CMD_CS_MSB:`CMD_CS_LSB] : cmdCs_reg) :
                        {CS_WIDTH{1'b1}};
      end
   end

   // Strobe pull-up on unless software disables it; forced on in reset
   assign readStrobePullup = !nrst || !ctrlPullupDis_reg;

   // Upper pins: GPIO role only when its function bit is set
   assign gpioDirFull = {gpioDir, {LOW_BITS{1'b0}}};
   assign gpioOutFull = {gpioOut, {LOW_BITS{1'b0}}};
   assign gpioRoleFull = {gpioFunc_reg, {LOW_BITS{1'b0}}};

   // GPIO role pins also become inputs under the strobe; bus role pins never drive here, write side is elsewhere
   assign extDataOe = gpioDirFull & gpioRoleFull & {DATA_WIDTH{!strobeLow}};
   assign extDataOut = gpioOutFull;
   assign extDataPullup = pullupEn_reg;
   assign gpioIn = dataSync2_reg[DATA_WIDTH-1:LOW_BITS];

endmodule // ext_mem_read

// [ext_mem_read_assertions.sv]
`include "ext_mem_read_consts.vh"
module ext_mem_read_assertions (
   input wire clock, // System clock
   input wire nrst, // Synchronous reset, active low
   input wire psel, penable, pwrite, // APB control
   input wire [11:0] paddr, // APB address
   input wire [31:0] pwdata, // APB write data
   input wire readStrobeN, readStrobeOe, readStrobePullup, // Strobe pin
   input wire [23:0] extAddrPins, // Address outputs
   input wire programSpaceSelectN, dataSpaceSelectN, // Space selects
   input wire [3:0] chipSelectN, // Chip selects
   input wire [15:0] extDataOe // Data pin enables
);
   reg [3:0] waitReg;
   reg [4:0] lowCnt;
   reg drvReg, pudReg;
   wire wr = psel && penable && pwrite;
   wire cmdWr = wr && paddr == `OFF_READ_CMD;
   // Mirror the control bits, so strobe length and idle drive can be judged
   always @(posedge clock)
   begin
      lowCnt <= (!nrst || readStrobeN) ? 5'h00 : lowCnt + 5'h01;
      if (!nrst)
         {waitReg, drvReg, pudReg} <= 6'h00;
      else if (wr && paddr == `OFF_BUS_CONTROL)
         {waitReg, drvReg} <= {pwdata[7:4], pwdata[0]};
      else if (wr && paddr == `OFF_SYS_PULLUP_DIS)
         pudReg <= pwdata[0];
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   property p_reset_quiet; disable iff (1'b0) !nrst |=> !readStrobeOe && readStrobeN && extDataOe == 16'h0000; endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("strobe or data driven in reset");
   property p_read_inputs; !readStrobeN |-> extDataOe == 16'h0000; endproperty
   a_read_inputs: assert property (p_read_inputs) else $error("data pin driven during read");
   property p_read_driven; !readStrobeN |-> readStrobeOe; endproperty
   a_read_driven: assert property (p_read_driven) else $error("low strobe not driven");
   property p_strobe_len; $rose(readStrobeN) |-> lowCnt == waitReg + 5'h03; endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("read strobe length wrong");
   property p_start; $fell(readStrobeN) |-> $past(cmdWr); endproperty
   a_start: assert property (p_start) else $error("strobe without read command");
   property p_addr_hold; !readStrobeN && !$past(readStrobeN) |-> $stable(extAddrPins) && $stable(chipSelectN); endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved during read");
   property p_one_space; !readStrobeN |-> programSpaceSelectN ^ dataSpaceSelectN; endproperty
   a_one_space: assert property (p_one_space) else $error("space selects wrong");
   property p_idle_drive; readStrobeN && $stable(drvReg) |-> readStrobeOe == drvReg; endproperty
   a_idle_drive: assert property (p_idle_drive) else $error("idle strobe drive wrong");
   property p_pullup; readStrobePullup != pudReg; endproperty
   a_pullup: assert property (p_pullup) else $error("strobe pull-up wrong");
endmodule // ext_mem_read_assertions
bind ext_mem_read ext_mem_read_assertions chk (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .readStrobeN, .readStrobeOe, .readStrobePullup, .extAddrPins, .programSpaceSelectN, .dataSpaceSelectN,
   .chipSelectN, .extDataOe);

// [sram_model.sv]
module sram_model (
   input wire clock, // System clock
   input wire readStrobeN, readStrobeOe, // Strobe level and enable
   input wire programSpaceSelectN, // High for data space
   input wire [23:0] extAddrPins, // Address from the block
   input wire [15:0] extDataPullup, // Pin pull-ups
   input wire [3:0] slowCycles, // Cycles before data appears
   output reg [15:0] extDataIn // Bus level seen by the block
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [4:0] lowCnt = 5'h00;
   initial extDataIn = 16'h0000;
   // Output enable tied to the strobe; released pins float to pull-ups or wander
   always @(posedge clock)
   begin
      lowCnt <= (readStrobeN || !readStrobeOe) ? 5'h00 : lowCnt + 5'h01;
      if (!readStrobeN && readStrobeOe && lowCnt >= {1'b0, slowCycles})
         extDataIn <= extAddrPins[15:0] ^ {15'h0000, programSpaceSelectN} ^ 16'h5A3C;
      else
         extDataIn <= ~extDataIn | extDataPullup;
   end
endmodule // sram_model

// [tb.sv]
`include "ext_mem_read_consts.vh"
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin errCount++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   reg clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h00000000, rdata;
   reg [8:0] gpioOut = 9'h000, gpioDir = 9'h000;
   reg [3:0] slowCycles = 4'h0;
   wire [31:0] prdata;
   wire pready, pslverr, readStrobeN, readStrobeOe, readStrobePullup, programSpaceSelectN, dataSpaceSelectN;
   wire [23:0] extAddrPins;
   wire [3:0] chipSelectN;
   wire [15:0] extDataIn, extDataOut, extDataOe, extDataPullup;
   wire [8:0] gpioIn;
   integer errCount = 0, checksDone = 0, seed = 32'h9BCA, i, n;
   ext_mem_read DUT (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .readStrobeN, .readStrobeOe, .readStrobePullup, .extAddrPins, .programSpaceSelectN, .dataSpaceSelectN,
      .chipSelectN, .extDataIn, .extDataOut, .extDataOe, .extDataPullup, .gpioOut, .gpioDir, .gpioIn);
   sram_model mem (.clock, .readStrobeN, .readStrobeOe, .programSpaceSelectN, .extAddrPins, .extDataPullup,
      .slowCycles, .extDataIn);
   always #5 clock = ~clock;
   function [15:0] memWord(input [23:0] a, input s);
      memWord = a[15:0] ^ {15'h0000, s} ^ 16'h5A3C;
   endfunction
   task conclude;
      begin
         $display("checks %0d errors %0d", checksDone, errCount);
         if (errCount == 0 && checksDone > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // One APB transfer; the request is held until pready is seen high
   task apb(input w, input [11:0] a, input [31:0] d);
      integer k;
      begin
         psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
         @(posedge clock);
         penable <= 1'b1;
         k = 0;
         do begin @(posedge clock); k++; end while (pready !== 1'b1 && k < 50);
         rdata = prdata;
         rerr = pslverr;
         psel <= 1'b0; penable <= 1'b0;
         @(posedge clock);
         if (k == 50) begin errCount++; conclude; end
      end
   endtask
   // Start a read cycle, look at the pins, poll for done, fetch the word
   task memRead(input [23:0] a, input s, input [3:0] m);
      integer k;
      begin
         apb(1'b1, `OFF_READ_ADDR, {8'h00, a});
         apb(1'b1, `OFF_READ_CMD, {24'h000000, m, 3'h0, s});
         `CHK("strobe", 1'b0, readStrobeN)
         `CHK("address", a, extAddrPins)
         `CHK("program select", s, programSpaceSelectN)
         `CHK("data select", ~s, dataSpaceSelectN)
         `CHK("chip select", ~m, chipSelectN)
         k = 0;
         do begin apb(1'b0, `OFF_STATUS, 32'h0); k++; end while (rdata[1] !== 1'b1 && k < 40);
         if (k == 40) begin errCount++; conclude; end
         apb(1'b0, `OFF_READ_DATA, 32'h0);
         `CHK("read data", memWord(a, s), rdata[15:0])
      end
   endtask
   initial
   begin
      repeat (5) @(posedge clock);
      `CHK("oe in reset", 1'b0, readStrobeOe)
      nrst <= 1'b1;
      @(posedge clock);
      apb(1'b0, `OFF_PORTF_FUNC, 32'h0);
      `CHK("port function", 16'h0000, rdata[15:0])
      apb(1'b0, 12'hFFC, 32'h0);
      `CHK("unmapped error", 1'b1, rerr)
      for (i = 0; i < 4; i++)
      begin
         n = (i == 0) ? 32'h0000FFFE : $random(seed);
         apb(1'b1, `OFF_PORTF_PULLUP, n);
         `CHK("data pullups", n[15:0], extDataPullup)
      end
      for (i = 1; i >= 0; i--)
      begin
         apb(1'b1, `OFF_SYS_PULLUP_DIS, i);
         `CHK("strobe pullup", ~i[0], readStrobePullup)
      end
      apb(1'b1, `OFF_BUS_CONTROL, 32'h00000020);
      `CHK("idle tristate", 1'b0, readStrobeOe)
      for (i = 0; i < 8; i++)
      begin
         if (i == 1) apb(1'b1, `OFF_BUS_CONTROL, 32'h00000021);
         if (i == 1)
         begin
            @(posedge clock);
            `CHK("idle driven", 1'b1, readStrobeOe)
         end
         if (i == 6) apb(1'b1, `OFF_BUS_CONTROL, 32'h000000F1);
         slowCycles <= (i >= 6) ? 4'hA : 4'h0;
         n = $random(seed);
         memRead(n[23:0], i[0], n[27:24]);
      end
      n = $random(seed);
      gpioDir <= n[8:0];
      gpioOut <= n[17:9];
      apb(1'b1, `OFF_PORTF_FUNC, 32'h000001FF);
      `CHK("gpio oe", {n[8:0], 7'h00}, extDataOe)
      `CHK("gpio out", n[17:9], extDataOut[15:7])
      apb(1'b1, `OFF_PORTF_FUNC, 32'h0);
      `CHK("bus role oe", 16'h0000, extDataOe)
      apb(1'b1, `OFF_READ_CMD, 32'h00000011);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      `CHK("strobe in reset", 1'b1, readStrobeN)
      nrst <= 1'b1;
      @(posedge clock);
      conclude;
   end
endmodule // tb
